// *** hw/ssm_pkg.sv ***
// Constants for the servo speed-mode parameter core: register map, factory values, limits.
// Assumes a single 250 MHz clock and an APB master on the register side.
package ssm_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_MODE       = 8'h00;
  localparam logic [7:0] OFS_MOTOR      = 8'h04;
  localparam logic [7:0] OFS_CABLE      = 8'h08;
  localparam logic [7:0] OFS_GEAR_NUM   = 8'h0C;
  localparam logic [7:0] OFS_GEAR_DEN   = 8'h10;
  localparam logic [7:0] OFS_MARKER     = 8'h14;
  localparam logic [7:0] OFS_STOP_THR   = 8'h18;
  localparam logic [7:0] OFS_COIN_TGT   = 8'h1C;
  localparam logic [7:0] OFS_COIN_WIDTH = 8'h20;
  localparam logic [7:0] OFS_TORQ_LIM   = 8'h24;
  localparam logic [7:0] OFS_ACCEL      = 8'h28;
  localparam logic [7:0] OFS_DECEL      = 8'h2C;
  localparam logic [7:0] OFS_SCURVE     = 8'h30;
  localparam logic [7:0] OFS_STATUS     = 8'h34;
  localparam logic [7:0] OFS_RESOL      = 8'h38;
  localparam logic [7:0] OFS_ACT_GEAR   = 8'h3C;
  // Factory values
  localparam logic [7:0]  FAC_MODE       = 8'h00;
  localparam logic [15:0] FAC_MOTOR      = 16'h0000;
  localparam logic [6:0]  FAC_CABLE      = 7'h05;
  localparam logic [14:0] FAC_GEAR       = 15'h0001;
  localparam logic [13:0] FAC_MARKER     = 14'h0000;
  localparam logic [11:0] FAC_STOP_THR   = 12'h032;
  localparam logic [11:0] FAC_COIN_TGT   = 12'h000;
  localparam logic [11:0] FAC_COIN_WIDTH = 12'h014;
  localparam logic [9:0]  FAC_TORQ_LIM   = 10'h3E8;
  localparam logic [11:0] FAC_TIME       = 12'h000;
  // Limits
  localparam logic [6:0]  CABLE_MIN  = 7'h01;
  localparam logic [6:0]  CABLE_MAX  = 7'h78;
  localparam logic [14:0] GEAR_MIN   = 15'h0001;
  localparam logic [13:0] ELEC_MAX   = 14'h2EDF;
  localparam logic [11:0] SPEED_MIN  = 12'h001;
  localparam logic [11:0] SPEED_MAX  = 12'hFA0;
  localparam logic [9:0]  TORQ_MAX   = 10'h3E8;
  localparam logic [11:0] TIME_MAX   = 12'hCCC;
  // Resolution per resolver cycle
  localparam int          ELEC_COUNTS = 12000;
  localparam logic [13:0] ELEC_CNT14  = 14'h2EE0;
  // Ramp time base: time values are in 10 ms units
  localparam int RAMP_TICK_MS = 10;
  localparam int CLK_HZ       = 250_000_000;
  localparam int RAMP_TICK_CYC = CLK_HZ / 1000 * RAMP_TICK_MS;
  // Status bits
  localparam int ST_STOPPED = 0;
  localparam int ST_COIN    = 1;
  localparam int ST_ENCODER = 2;
  localparam int ST_STOPPOS = 3;
  typedef enum logic [1:0] {
    SSM_QD_IDLE,
    SSM_QD_UP,
    SSM_QD_DOWN
  } ssm_qstep_t;
endpackage

// *** hw/ssm_core.sv ***
// Servo speed-mode parameter core: APB parameter file, gear scaling, zero marker,
// speed status, torque clamp and linear acceleration ramp.
// Assumes pins are asynchronous and speed/torque/feedback inputs come from same-clock logic.
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module ssm_core #(
  parameter int RAMP_TICK = ssm_pkg::RAMP_TICK_CYC // Cycles per ramp tick
) (
  input  wire logic        i_sys_clk,        // System clock
  input  wire logic        i_rst,            // Sync reset, power-on
  input  wire logic        i_pwr_restart,    // Power cycle pulse, loads latched params
  input  wire logic        i_psel,           // APB select
  input  wire logic        i_penable,        // APB enable
  input  wire logic        i_pwrite,         // APB write
  input  wire logic [7:0]  i_paddr,          // APB byte address
  input  wire logic [31:0] i_pwdata,         // APB write data
  output logic      [31:0] o_prdata,         // APB read data
  output logic             o_pready,         // APB ready
  output logic             o_pslverr,        // APB error, unmapped or read-only write
  input  wire logic        i_cmd_pulse_a,    // Command quadrature A pin
  input  wire logic        i_cmd_pulse_b,    // Command quadrature B pin
  input  wire logic        i_stop_at_marker, // Stop at marker pin
  input  wire logic        i_fb_step,        // Feedback count pulse
  input  wire logic        i_fb_dir,         // Feedback direction, 1 up
  input  wire logic        i_encoder_fitted, // Encoder instead of resolver
  input  wire logic [3:0]  i_res_cycles,     // Resolver cycles per rev
  input  wire logic [19:0] i_enc_ppr,        // Encoder pulses per rev
  input  wire logic [15:0] i_speed_rpm,      // Measured speed, signed
  input  wire logic [15:0] i_cmd_speed,      // Commanded speed, signed
  input  wire logic [12:0] i_rated_rpm,      // Rated speed
  input  wire logic        i_torque_limit_en,// Torque limit applied
  input  wire logic [15:0] i_torque_req,     // Torque request, signed
  input  wire logic [15:0] i_peak_torque,    // Peak torque magnitude
  output logic             o_fb_pulse_a,     // Feedback quadrature A
  output logic             o_fb_pulse_b,     // Feedback quadrature B
  output logic             o_zero_marker_out,// Zero marker pulse
  output logic             o_stop_hold,      // Stop here request
  output logic             o_cmd_step,       // Internal command count pulse
  output logic             o_cmd_dir,        // Internal command direction
  output logic             o_motor_stopped,  // Motor stopped
  output logic             o_speed_match,    // Speed coincidence
  output logic      [15:0] o_torque_cmd,     // Clamped torque
  output logic      [15:0] o_ramp_speed,     // Ramped speed reference
  output logic      [7:0]  o_mode,           // Active operating mode
  output logic      [15:0] o_motor_code,     // Active motor profile
  output logic      [6:0]  o_cable_comp,     // Active cable length, 0 on encoder
  output logic      [19:0] o_resolution      // Counts per revolution
);
  import ssm_pkg::*;

  // Pending (written) and active (latched at restart) parameters
  logic [7:0]  mode_p_r, mode_r;
  logic [15:0] motor_p_r, motor_r;
  logic [6:0]  cable_p_r, cable_r;
  logic [14:0] num_p_r, num_r, den_p_r, den_r;
  logic [13:0] marker_r;
  logic [11:0] stop_thr_r, coin_tgt_r, coin_w_r, accel_r, decel_r, scurve_r;
  logic [9:0]  torq_lim_r;

  function automatic logic [11:0] clip12(input logic [31:0] v, input logic [11:0] lo,
                                         input logic [11:0] hi);
    if (v < {20'h0, lo}) return lo;
    if (v > {20'h0, hi}) return hi;
    return v[11:0];
  endfunction

  function automatic logic [15:0] abs16(input logic [15:0] v);
    return v[15] ? 16'(-v) : v;
  endfunction

  function automatic ssm_qstep_t qdec(input logic [1:0] old_ab, input logic [1:0] new_ab);
    logic [1:0] o_g, n_g;
    o_g = {old_ab[1], old_ab[1] ^ old_ab[0]};
    n_g = {new_ab[1], new_ab[1] ^ new_ab[0]};
    if (n_g == 2'(o_g + 2'h1)) return SSM_QD_UP;
    if (n_g == 2'(o_g - 2'h1)) return SSM_QD_DOWN;
    return SSM_QD_IDLE;
  endfunction

  // APB decode
  wire        acc_w    = i_psel & i_penable & ~o_pready;
  // Writes land at the completing edge, with pready seen high
  wire        wr_w     = i_psel & i_penable & o_pready & i_pwrite;
  wire [31:0] wd       = i_pwdata;
  wire        mapped_w = (i_paddr[1:0] == 2'h0) && (i_paddr <= OFS_ACT_GEAR);
  wire        ro_w     = (i_paddr == OFS_STATUS) || (i_paddr == OFS_RESOL) ||
                         (i_paddr == OFS_ACT_GEAR);
  wire [14:0] gear_w   = (wd[14:0] < GEAR_MIN) ? GEAR_MIN : wd[14:0];
  wire [6:0]  cable_w  = (wd > 32'(CABLE_MAX)) ? CABLE_MAX :
                         (wd[6:0] < CABLE_MIN) ? CABLE_MIN : wd[6:0];
  wire [13:0] marker_w = (wd > 32'(ELEC_MAX)) ? ELEC_MAX : wd[13:0];
  wire [9:0]  torq_w   = (wd > 32'(TORQ_MAX)) ? TORQ_MAX : wd[9:0];
  wire [11:0] time_w   = clip12(wd, FAC_TIME, TIME_MAX);
  wire [11:0] spd_w    = clip12(wd, SPEED_MIN, SPEED_MAX);
  wire [11:0] tgt_w    = clip12(wd, FAC_COIN_TGT, SPEED_MAX);
  wire [3:0]  status_w = {o_stop_hold, i_encoder_fitted, o_speed_match, o_motor_stopped};
  logic [31:0] rd_w;
  always_comb begin
    unique case (i_paddr)
      OFS_MODE:       rd_w = {24'h0, mode_p_r};
      OFS_MOTOR:      rd_w = {16'h0, motor_p_r};
      OFS_CABLE:      rd_w = {25'h0, cable_p_r};
      OFS_GEAR_NUM:   rd_w = {17'h0, num_p_r};
      OFS_GEAR_DEN:   rd_w = {17'h0, den_p_r};
      OFS_MARKER:     rd_w = {18'h0, marker_r};
      OFS_STOP_THR:   rd_w = {20'h0, stop_thr_r};
      OFS_COIN_TGT:   rd_w = {20'h0, coin_tgt_r};
      OFS_COIN_WIDTH: rd_w = {20'h0, coin_w_r};
      OFS_TORQ_LIM:   rd_w = {22'h0, torq_lim_r};
      OFS_ACCEL:      rd_w = {20'h0, accel_r};
      OFS_DECEL:      rd_w = {20'h0, decel_r};
      OFS_SCURVE:     rd_w = {20'h0, scurve_r};
      OFS_STATUS:     rd_w = {28'h0, status_w};
      OFS_RESOL:      rd_w = {12'h0, o_resolution};
      OFS_ACT_GEAR:   rd_w = {1'b0, den_r, 1'b0, num_r};
      default:        rd_w = 32'h0;
    endcase
  end

  // APB answer one cycle into the access phase
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0;
    end else begin
      o_pready  <= acc_w;
      o_pslverr <= acc_w & (~mapped_w | (i_pwrite & ro_w));
      o_prdata  <= (acc_w & ~i_pwrite & mapped_w) ? rd_w : 32'h0;
    end
  end

  // Parameter writes; live parameters act at once, except the marker offset, which is used only at the next restart
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      mode_p_r   <= FAC_MODE;
      motor_p_r  <= FAC_MOTOR;
      cable_p_r  <= FAC_CABLE;
      num_p_r    <= FAC_GEAR;
      den_p_r    <= FAC_GEAR;
      marker_r   <= FAC_MARKER;
      stop_thr_r <= FAC_STOP_THR;
      coin_tgt_r <= FAC_COIN_TGT;
      coin_w_r   <= FAC_COIN_WIDTH;
      torq_lim_r <= FAC_TORQ_LIM;
      accel_r    <= FAC_TIME;
      decel_r    <= FAC_TIME;
      scurve_r   <= FAC_TIME;
    end else if (wr_w) begin
      unique case (i_paddr)
        OFS_MODE:       mode_p_r   <= wd[7:0];
        OFS_MOTOR:      motor_p_r  <= wd[15:0];
        OFS_CABLE:      cable_p_r  <= cable_w;
        OFS_GEAR_NUM:   num_p_r    <= gear_w;
        OFS_GEAR_DEN:   den_p_r    <= gear_w;
        OFS_MARKER:     marker_r   <= marker_w;
        OFS_STOP_THR:   stop_thr_r <= spd_w;
        OFS_COIN_TGT:   coin_tgt_r <= tgt_w;
        OFS_COIN_WIDTH: coin_w_r   <= spd_w;
        OFS_TORQ_LIM:   torq_lim_r <= torq_w;
        OFS_ACCEL:      accel_r    <= time_w;
        OFS_DECEL:      decel_r    <= time_w;
        OFS_SCURVE:     scurve_r   <= time_w;
        default:        ;
      endcase
    end
  end

  // Latched parameters take effect only at a power restart
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      mode_r  <= FAC_MODE;
      motor_r <= FAC_MOTOR;
      cable_r <= FAC_CABLE;
      num_r   <= FAC_GEAR;
      den_r   <= FAC_GEAR;
    end else if (i_pwr_restart) begin
      mode_r  <= mode_p_r;
      motor_r <= motor_p_r;
      cable_r <= cable_p_r;
      num_r   <= num_p_r;
      den_r   <= den_p_r;
    end
  end

  // Profile outputs and resolution
  wire [19:0] res_w = i_encoder_fitted ? i_enc_ppr : 20'(i_res_cycles) * 20'(ELEC_CNT14);
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_mode       <= FAC_MODE;
      o_motor_code <= FAC_MOTOR;
      o_cable_comp <= 7'h0;
      o_resolution <= 20'h0;
    end else begin
      o_mode       <= mode_r;
      o_motor_code <= motor_r;
      o_cable_comp <= i_encoder_fitted ? 7'h0 : cable_r;
      o_resolution <= res_w;
    end
  end

  // Pin synchronisers, three stages, accepted when stages two and three agree
  logic [2:0] sa_r, sb_r, ss_r;
  logic [1:0] cmd_ab_r;
  logic       stop_in_r;
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sa_r      <= 3'h0;
      sb_r      <= 3'h0;
      ss_r      <= 3'h0;
      cmd_ab_r  <= 2'h0;
      stop_in_r <= 1'b0;
    end else begin
      sa_r <= {sa_r[1:0], i_cmd_pulse_a};
      sb_r <= {sb_r[1:0], i_cmd_pulse_b};
      ss_r <= {ss_r[1:0], i_stop_at_marker};
      if (sa_r[1] == sa_r[2]) cmd_ab_r[1] <= sa_r[2];
      if (sb_r[1] == sb_r[2]) cmd_ab_r[0] <= sb_r[2];
      if (ss_r[1] == ss_r[2]) stop_in_r <= ss_r[2];
    end
  end

  // Command gearing: each input count adds numerator, each output count removes denominator
  wire [1:0]  cmd_ab_new = {(sa_r[1] == sa_r[2]) ? sa_r[2] : cmd_ab_r[1],
                            (sb_r[1] == sb_r[2]) ? sb_r[2] : cmd_ab_r[0]};
  wire ssm_qstep_t cq_w  = qdec(cmd_ab_r, cmd_ab_new);
  logic signed [31:0] cacc_r;
  wire signed [31:0] cin_w = (cq_w == SSM_QD_UP)   ? 32'(num_r) :
                             (cq_w == SSM_QD_DOWN) ? -32'(num_r) : 32'sh0;
  wire c_up_w = cacc_r >= $signed(32'(den_r));
  wire c_dn_w = cacc_r <= -$signed(32'(den_r));
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || i_pwr_restart) begin
      cacc_r     <= 32'sh0;
      o_cmd_step <= 1'b0;
      o_cmd_dir  <= 1'b0;
    end else begin
      cacc_r     <= cacc_r + cin_w - (c_up_w ? $signed(32'(den_r)) : 32'sh0)
                           + (c_dn_w ? $signed(32'(den_r)) : 32'sh0);
      o_cmd_step <= c_up_w | c_dn_w;
      o_cmd_dir  <= c_up_w;
    end
  end

  // Feedback gearing and quadrature output, one output edge per cycle at most
  logic signed [31:0] facc_r;
  logic [1:0]         fq_r;
  wire signed [31:0] fin_w = i_fb_step ? (i_fb_dir ? 32'(den_r) : -32'(den_r)) : 32'sh0;
  wire f_up_w = facc_r >= $signed(32'(num_r));
  wire f_dn_w = facc_r <= -$signed(32'(num_r));
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || i_pwr_restart) begin
      facc_r       <= 32'sh0;
      fq_r         <= 2'h0;
      o_fb_pulse_a <= 1'b0;
      o_fb_pulse_b <= 1'b0;
    end else begin
      facc_r <= facc_r + fin_w - (f_up_w ? $signed(32'(num_r)) : 32'sh0)
                       + (f_dn_w ? $signed(32'(num_r)) : 32'sh0);
      if (f_up_w) fq_r <= 2'(fq_r + 2'h1);
      else if (f_dn_w) fq_r <= 2'(fq_r - 2'h1);
      o_fb_pulse_a <= fq_r[1];
      o_fb_pulse_b <= fq_r[1] ^ fq_r[0];
    end
  end

  // Electrical position within one zero period, preset at restart to the period minus the marker offset
  wire [19:0] per_w  = i_encoder_fitted ? i_enc_ppr : 20'(ELEC_COUNTS);
  wire [13:0] ofs_w  = i_encoder_fitted ? 14'h0 : marker_r;
  wire [19:0] epre_w = (ofs_w == 14'h0) ? 20'h0 : 20'(per_w - 20'(ofs_w));
  logic [19:0] epos_r;
  logic        stop_arm_r;
  wire wrap_up_w = i_fb_step & i_fb_dir & (epos_r == 20'(per_w - 20'h1));
  wire wrap_dn_w = i_fb_step & ~i_fb_dir & (epos_r == 20'h0);
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || i_pwr_restart) begin
      epos_r            <= i_rst ? 20'h0 : epre_w;
      o_zero_marker_out <= 1'b0;
      stop_arm_r        <= 1'b0;
      o_stop_hold       <= 1'b0;
    end else begin
      if (wrap_up_w) epos_r <= 20'h0;
      else if (wrap_dn_w) epos_r <= 20'(per_w - 20'h1);
      else if (i_fb_step) epos_r <= i_fb_dir ? 20'(epos_r + 20'h1) : 20'(epos_r - 20'h1);
      o_zero_marker_out <= wrap_up_w | wrap_dn_w;
      stop_arm_r  <= stop_in_r & ~o_stop_hold & ~(wrap_up_w | wrap_dn_w);
      o_stop_hold <= stop_in_r & (o_stop_hold | (stop_arm_r & (wrap_up_w | wrap_dn_w)));
    end
  end
  // Speed status
  wire [15:0] spd_abs_w = abs16(i_speed_rpm);
  wire [15:0] tgt_sel_w = (coin_tgt_r != 12'h0) ? {4'h0, coin_tgt_r}
                                                : abs16(i_cmd_speed);
  wire [15:0] diff_w    = (spd_abs_w > tgt_sel_w) ? 16'(spd_abs_w - tgt_sel_w)
                                                  : 16'(tgt_sel_w - spd_abs_w);
  // Torque clamp, limit in 0.1 % of peak
  wire [25:0] lim_w     = 26'((32'(i_peak_torque) * 32'(torq_lim_r)) / 32'(TORQ_MAX));
  wire [15:0] treq_abs  = abs16(i_torque_req);
  wire        clamp_w   = i_torque_limit_en && ({10'h0, treq_abs} > lim_w);
  wire [15:0] lim16_w   = i_torque_req[15] ? 16'(-lim_w[15:0]) : lim_w[15:0];
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_motor_stopped <= 1'b1;
      o_speed_match   <= 1'b0;
      o_torque_cmd    <= 16'h0;
    end else begin
      o_motor_stopped <= spd_abs_w < {4'h0, stop_thr_r};
      o_speed_match   <= diff_w <= {4'h0, coin_w_r};
      o_torque_cmd    <= clamp_w ? lim16_w : i_torque_req;
    end
  end

  // Ramp tick and linear speed ramp; step rate = rated / time per tick
  logic [31:0] tick_cnt_r, frac_r;
  wire         tick_w   = (tick_cnt_r == 32'(RAMP_TICK - 1));
  wire [15:0]  ramp_abs = abs16(o_ramp_speed);
  wire         accel_w  = (abs16(i_cmd_speed) > ramp_abs) &&
                          ((o_ramp_speed == 16'h0) || (o_ramp_speed[15] == i_cmd_speed[15]));
  wire [11:0]  time_sel = (scurve_r != 12'h0) ? scurve_r
                        : (accel_w ? accel_r : decel_r);
  wire         step_w   = frac_r >= 32'(time_sel);
  wire         up_w     = $signed(i_cmd_speed) > $signed(o_ramp_speed);
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      tick_cnt_r   <= 32'h0;
      frac_r       <= 32'h0;
      o_ramp_speed <= 16'h0;
    end else begin
      tick_cnt_r <= tick_w ? 32'h0 : 32'(tick_cnt_r + 32'h1);
      if (time_sel == 12'h0) begin
        o_ramp_speed <= i_cmd_speed;
        frac_r       <= 32'h0;
      end else if (o_ramp_speed == i_cmd_speed) begin
        frac_r <= 32'h0;
      end else if (step_w) begin
        o_ramp_speed <= up_w ? 16'(o_ramp_speed + 16'h1) : 16'(o_ramp_speed - 16'h1);
        frac_r       <= 32'(frac_r - 32'(time_sel) + (tick_w ? 32'(i_rated_rpm) : 32'h0));
      end else if (tick_w) begin
        frac_r <= 32'(frac_r + 32'(i_rated_rpm));
      end
    end
  end
endmodule // ssm_core
`default_nettype wire

// *** sim/ssm_core_sva.sv ***
// Checker on the servo parameter core ports: APB timing, status and pulse relations.
// Assumes one clock domain with the synchronous active-high reset of the core.
`timescale 1ns/1ps
`default_nettype none
module ssm_core_sva (
  input wire logic        i_sys_clk,         // Clock
  input wire logic        i_rst,             // Reset
  input wire logic        i_pwr_restart,     // Restart pulse
  input wire logic        i_psel,            // APB select
  input wire logic        i_penable,         // APB enable
  input wire logic [15:0] i_speed_rpm,       // Measured speed
  input wire logic        i_encoder_fitted,  // Encoder fitted
  input wire logic        i_torque_limit_en, // Limit applied
  input wire logic [15:0] i_torque_req,      // Torque request
  input wire logic        o_pready,          // Ready
  input wire logic        o_pslverr,         // Error
  input wire logic        o_fb_pulse_a,      // Feedback A
  input wire logic        o_fb_pulse_b,      // Feedback B
  input wire logic        o_zero_marker_out, // Marker pulse
  input wire logic        o_motor_stopped,   // Stopped flag
  input wire logic [15:0] o_torque_cmd,      // Torque out
  input wire logic [7:0]  o_mode,            // Active mode
  input wire logic [15:0] o_motor_code       // Active motor code
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // APB answer one cycle after the access is taken, only inside a held access
  sequence s_access; i_psel && i_penable && !o_pready; endsequence
  property p_ready_next; s_access |=> o_pready; endproperty
  a_ready_next: assert property (p_ready_next) else $error("pready missing after access");
  property p_ready_held; o_pready |-> i_psel && i_penable && $past(i_penable); endproperty
  a_ready_held: assert property (p_ready_held) else $error("pready outside an access");
  property p_err_ready; o_pslverr |-> o_pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  // Status, latched parameters, pulses and torque path
  property p_stopped; $past(i_speed_rpm) == 16'h0000 |-> o_motor_stopped; endproperty
  a_stopped: assert property (p_stopped) else $error("stopped flag low at zero speed");
  property p_hold;
    !$past(i_rst) && !$past(i_pwr_restart) && !$past(i_pwr_restart, 2)
      |-> $stable(o_mode) && $stable(o_motor_code);
  endproperty
  a_hold: assert property (p_hold) else $error("active parameter moved while running");
  property p_gray;
    !$past(i_rst) && !$past(i_rst, 2) && !$past(i_pwr_restart) && !$past(i_pwr_restart, 2)
      |-> !($changed(o_fb_pulse_a) && $changed(o_fb_pulse_b));
  endproperty
  a_gray: assert property (p_gray) else $error("both feedback lines moved at once");
  property p_marker; o_zero_marker_out && !i_encoder_fitted |=> !o_zero_marker_out; endproperty
  a_marker: assert property (p_marker) else $error("marker pulse longer than one cycle");
  property p_torque;
    !$past(i_rst) && !$past(i_torque_limit_en) |-> o_torque_cmd == $past(i_torque_req);
  endproperty
  a_torque: assert property (p_torque) else $error("torque altered while not limited");
endmodule // ssm_core_sva
bind ssm_core ssm_core_sva i_ssm_core_sva (.*);
`default_nettype wire

// *** sim/ssm_cmd_src.sv ***
// Quadrature command source standing in for the external motion controller.
// Assumes the bench strobes one count at a time on the core clock.
`timescale 1ns/1ps
`default_nettype none
module ssm_cmd_src (
  input  wire logic i_sys_clk, // Clock
  input  wire logic i_step,    // One count request
  input  wire logic i_up,      // Count direction
  output logic      o_a,       // Quadrature A
  output logic      o_b        // Quadrature B
);
  logic [1:0] pos_r = 2'h0;
  // Gray-coded position, one line moves per count
  always @(posedge i_sys_clk) begin
    if (i_step) pos_r <= i_up ? pos_r + 2'h1 : pos_r - 2'h1;
  end
  assign o_a = pos_r[1];
  assign o_b = pos_r[1] ^ pos_r[0];
endmodule // ssm_cmd_src
`default_nettype wire

// *** sim/ssm_core_test.sv ***
// Self-checking bench for the servo parameter core, scenario tasks over APB and pins.
// Assumes the core answers APB with one wait state and a short ramp tick.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ssm_core_test;
  logic        i_sys_clk = 1'b0, i_rst = 1'b1, i_pwr_restart = 1'b0, i_psel = 1'b0;
  logic        i_penable = 1'b0, i_pwrite = 1'b0, i_stop_at_marker = 1'b0, i_fb_step = 1'b0;
  logic        i_fb_dir = 1'b1, i_encoder_fitted = 1'b0, i_torque_limit_en = 1'b0;
  logic        q_step = 1'b0, q_up = 1'b1, i_cmd_pulse_a, i_cmd_pulse_b;
  logic [7:0]  i_paddr = 8'h00, o_mode;
  logic [31:0] i_pwdata = 32'h0, o_prdata;
  logic [3:0]  i_res_cycles = 4'h1;
  logic [19:0] i_enc_ppr = 20'h003E8, o_resolution;
  logic [12:0] i_rated_rpm = 13'h0008;
  logic [15:0] i_speed_rpm = 16'h0, i_cmd_speed = 16'h0, i_torque_req = 16'h0;
  logic [15:0] i_peak_torque = 16'h03E8, o_torque_cmd, o_ramp_speed, o_motor_code;
  logic        o_pready, o_pslverr, o_fb_pulse_a, o_fb_pulse_b, o_zero_marker_out;
  logic        o_stop_hold, o_cmd_step, o_cmd_dir, o_motor_stopped, o_speed_match;
  logic [6:0]  o_cable_comp;
  logic [1:0]  fb_prev = 2'h0;
  int          fail_count = 0, compares = 0, n_up, n_dn, n_fb, n_mk;
  localparam logic [31:0] FV [11] = '{32'h0, 32'h0, 32'h5, 32'h1, 32'h1, 32'h0, 32'h32,
                                      32'h0, 32'h14, 32'h3E8, 32'h0};
  localparam logic [15:0] SP [8] = '{16'h0031, 16'h0032, 16'h03FC, 16'h03FD,
                                     16'h01E0, 16'h01DF, 16'h0208, 16'h0209};
  localparam logic [1:0]  SX [8] = '{2'h2, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0};
  ssm_core #(.RAMP_TICK(8)) i_ssm_core (.*);
  ssm_cmd_src i_ssm_cmd_src (.i_sys_clk(i_sys_clk), .i_step(q_step), .i_up(q_up),
                             .o_a(i_cmd_pulse_a), .o_b(i_cmd_pulse_b));
  // Clock, 4 ns period
  initial begin
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  // Tallies of output events
  always @(posedge i_sys_clk) begin
    if (o_cmd_step === 1'b1) begin
      if (o_cmd_dir === 1'b1) n_up++;
      else n_dn++;
    end
    if ({o_fb_pulse_a, o_fb_pulse_b} !== fb_prev) n_fb++;
    if (o_zero_marker_out === 1'b1) n_mk++;
    fb_prev = {o_fb_pulse_a, o_fb_pulse_b};
  end
  task automatic w(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  // One APB transfer, checks read data and error
  task automatic acc(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] xd, input logic xe);
    int n;
    n = 0;
    i_psel <= 1'b1;
    i_pwrite <= wr_en;
    i_paddr <= a;
    i_pwdata <= d;
    w(1);
    i_penable <= 1'b1;
    do begin
      w(1);
      n++;
    end while (o_pready !== 1'b1 && n < 50);
    if (n == 50) begin
      fail_count++;
      report_and_stop();
    end
    `CHK(o_prdata, xd)
    `CHK(o_pslverr, xe)
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    w(1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d, 32'h0, 1'b0);
  endtask
  task automatic pr;
    i_pwr_restart <= 1'b1;
    w(1);
    i_pwr_restart <= 1'b0;
    w(3);
  endtask
  task automatic qs(input logic up, input int k);
    q_up <= up;
    repeat (k) begin
      q_step <= 1'b1;
      w(1);
      q_step <= 1'b0;
      w(7);
    end
  endtask
  task automatic t_factory;
    for (int k = 0; k < 11; k++) acc(1'b0, 8'(4 * k), 32'h0, FV[k], 1'b0);
    acc(1'b0, 8'h34, 32'h0, 32'h3, 1'b0);
    acc(1'b0, 8'h38, 32'h0, 32'h2EE0, 1'b0);
    acc(1'b1, 8'h38, 32'h1, 32'h0, 1'b1);
    acc(1'b0, 8'h40, 32'h0, 32'h0, 1'b1);
  endtask
  task automatic t_modes;
    for (int m = 1; m < 7; m++) begin
      wr(8'h00, 32'(m));
      `CHK(o_mode, 8'(m - 1))
      pr();
      `CHK(o_mode, 8'(m))
    end
    wr(8'h04, 32'hABCD);
    wr(8'h08, 32'hC8);
    wr(8'h0C, 32'h3);
    wr(8'h10, 32'h2);
    acc(1'b0, 8'h08, 32'h0, 32'h78, 1'b0);
    `CHK({o_motor_code, o_cable_comp}, {16'h0000, 7'h05})
    pr();
    `CHK({o_motor_code, o_cable_comp}, {16'hABCD, 7'h78})
    acc(1'b0, 8'h3C, 32'h0, 32'h0002_0003, 1'b0);
  endtask
  task automatic t_gear;
    n_up = 0;
    n_dn = 0;
    qs(1'b1, 4);
    qs(1'b0, 2);
    w(10);
    `CHK(n_up, 6)
    `CHK(n_dn, 3)
  endtask
  task automatic t_fb;
    n_fb = 0;
    n_mk = 0;
    i_stop_at_marker <= 1'b1;
    repeat (12000) begin
      i_fb_step <= 1'b1;
      w(1);
      i_fb_step <= 1'b0;
      w(1);
    end
    w(6);
    `CHK(n_fb, 8000)
    `CHK(n_mk, 1)
    `CHK(o_stop_hold, 1'b1)
    i_stop_at_marker <= 1'b0;
    w(8);
    `CHK(o_stop_hold, 1'b0)
    wr(8'h14, 32'h3);
    pr();
    n_mk = 0;
    repeat (3) begin
      i_fb_step <= 1'b1;
      w(1);
      i_fb_step <= 1'b0;
      w(1);
    end
    w(2);
    `CHK(n_mk, 1)
  endtask
  task automatic t_res;
    i_res_cycles <= 4'h2;
    w(4);
    `CHK(o_resolution, 20'h05DC0)
    i_encoder_fitted <= 1'b1;
    w(4);
    `CHK({o_resolution, o_cable_comp}, {20'h003E8, 7'h00})
    i_encoder_fitted <= 1'b0;
    i_res_cycles <= 4'h1;
  endtask
  task automatic t_speed;
    i_cmd_speed <= 16'h03E8;
    for (int k = 0; k < 8; k++) begin
      if (k == 4) wr(8'h1C, 32'h1F4);
      i_speed_rpm <= SP[k];
      w(3);
      `CHK({o_motor_stopped, o_speed_match}, SX[k])
    end
    i_speed_rpm <= 16'h0;
    i_cmd_speed <= 16'h0;
  endtask
  task automatic t_drive;
    wr(8'h24, 32'h1F4);
    i_torque_limit_en <= 1'b1;
    i_torque_req <= 16'h0320;
    w(3);
    `CHK(o_torque_cmd, 16'h01F4)
    i_torque_req <= 16'hFCE0;
    w(3);
    `CHK(o_torque_cmd, 16'hFE0C)
    i_torque_limit_en <= 1'b0;
    wr(8'h28, 32'h2);
    i_cmd_speed <= 16'h0008;
    w(4);
    `CHK(o_ramp_speed < 16'h0008, 1'b1)
    w(40);
    `CHK(o_ramp_speed, 16'h0008)
  endtask
  task automatic report_and_stop;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Reset for three cycles, then the scenarios
  initial begin
    w(3);
    i_rst <= 1'b0;
    w(2);
    t_factory();
    t_modes();
    t_gear();
    t_fb();
    t_res();
    t_speed();
    t_drive();
    report_and_stop();
  end
endmodule // ssm_core_test
`default_nettype wire
